/* common/afesc_pkg.sv */
package afesc_pkg;
  // Link widths
  localparam int NIB_W = 4;
  localparam int WORD_W = 16;
  localparam int REG_W = 12;
  localparam int ADDR_W = 3;
  localparam int NREG = 8;
  // Phase of the word clock strobe (one pclk in four)
  localparam logic [1:0] PH_LAST = 2'h3;
  // Serial burst counts, in word-clock slots
  localparam logic [3:0] BURST_TAIL = 4'hE;
  localparam logic [4:0] SEND_SLOTS = 5'h10;
  localparam logic [3:0] READ_BITS = 4'hC;
  localparam logic [3:0] READ_WAIT_SLOTS = 4'h8;
  // Device register addresses
  localparam logic [2:0] REG_RXGAIN = 3'h0;
  localparam logic [2:0] REG_CFG = 3'h2;
  localparam logic [2:0] REG_VCXO = 3'h3;
  localparam logic [2:0] REG_TONE = 3'h6;
  localparam logic [2:0] REG_STATUS = 3'h7;
  // Device register reset values
  localparam logic [11:0] DEF_ZERO = 12'h000;
  localparam logic [11:0] DEF_CFG = 12'h200;
  localparam logic [11:0] DEF_VCXO = 12'h800;
  localparam logic [11:0] DEF_TONE = 12'h800;
  // Field positions inside the 12 data bits (burst bit minus 3)
  localparam int GAIN_MSB_POS = 11;
  localparam int GAIN_LSB_POS = 10;
  localparam int PGA_LO = 4;
  localparam int PGA_W = 5;
  localparam int ATTEN_LO = 2;
  localparam int ATTEN_W = 2;
  localparam int DAC_LO = 4;
  localparam int DAC_W = 8;
  localparam int RXCLIP_POS = 11;
  localparam int TXCLIP_POS = 10;
  localparam int SLEEP_POS = 9;
  localparam int TONESEL_POS = 8;
  localparam int DEBUG_POS = 7;
  localparam int SWRST_POS = 6;
  // Host APB register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0C;
  // Host CMD fields
  localparam int CMD_READ_POS = 15;
  localparam int CMD_ADDR_LO = 12;
  // Host STATUS bits
  localparam int ST_BUSY = 0;
  localparam int ST_TONE = 1;
  localparam int ST_RDDONE = 2;
  localparam int ST_RDTMO = 3;
  localparam int ST_REFUSED = 4;

  function automatic logic [11:0] reg_default(input logic [2:0] a);
    case (a)
      REG_CFG: reg_default = DEF_CFG;
      REG_VCXO: reg_default = DEF_VCXO;
      REG_TONE: reg_default = DEF_TONE;
      default: reg_default = DEF_ZERO;
    endcase
  endfunction

  function automatic logic [3:0] nib_sel(input logic [15:0] w, input logic [1:0] i);
    nib_sel = w[{i, 2'b00} +: 4];
  endfunction
endpackage

/* common/afesc_if.sv */
`timescale 1ns/1ps
interface afesc_if (
  input wire logic pclk
);
  logic hard_reset_low;
  logic suspend;
  logic power_down_pin;
  logic master_clock_out;
  logic word_clock;
  logic ctl_serial_in;
  logic read_write_select;
  logic ctl_serial_out;
  logic ctl_serial_out_oe_n;
  logic [3:0] tx_nibble;
  logic [3:0] rx_nibble;
  logic tone_wake_flag;

  modport dev (
    input pclk, hard_reset_low, suspend, power_down_pin, ctl_serial_in,
    input read_write_select, tx_nibble,
    output master_clock_out, word_clock, ctl_serial_out, ctl_serial_out_oe_n,
    output rx_nibble, tone_wake_flag
  );
  modport host (
    input pclk, master_clock_out, word_clock, ctl_serial_out, ctl_serial_out_oe_n,
    input rx_nibble, tone_wake_flag,
    output hard_reset_low, suspend, power_down_pin, ctl_serial_in,
    output read_write_select, tx_nibble
  );
endinterface

/* rtl/afesc_dev.sv */
`timescale 1ns/1ps
module afesc_dev (
  // Link to the controller
  afesc_if.dev link,
  // Data words
  input wire logic [15:0] rx_word,
  output logic [15:0] tx_word,
  output logic tx_word_valid,
  // Tone detector and clip events
  input wire logic tone_40_active,
  input wire logic tone_72_active,
  input wire logic rx_clip_evt,
  input wire logic tx_clip_evt,
  // Analog controls
  output logic low_power,
  output logic ext_gain_msb,
  output logic ext_gain_lsb,
  output logic [4:0] rx_pga_gain,
  output logic [1:0] rx_atten_sel,
  output logic [7:0] vcxo_current_out
);
  typedef enum logic [1:0] {
    CI_IDLE = 2'b00,
    CI_DATA = 2'b01,
    CI_STOP = 2'b10
  } afesc_ci_t;

  logic rstn;
  logic [1:0] ph;
  logic [11:0] regs [afesc_pkg::NREG];
  logic [15:0] tx_acc;
  logic [15:0] rx_hold;
  afesc_ci_t ci_st;
  logic [3:0] ci_cnt;
  logic [14:0] ci_sh;
  logic ci_rd;
  logic [11:0] out_sh;
  logic [3:0] out_cnt;
  logic wc;
  logic stop_ok;
  logic wr_en;
  logic rd_go;
  logic debug;
  logic tone_hit;

  assign rstn = link.hard_reset_low;
  assign wc = link.word_clock;
  assign debug = regs[afesc_pkg::REG_STATUS][afesc_pkg::DEBUG_POS];
  assign stop_ok = wc && (ci_st == CI_STOP) && link.ctl_serial_in;
  assign wr_en = stop_ok && !ci_rd;
  assign rd_go = stop_ok && ci_rd;
  assign tone_hit = regs[afesc_pkg::REG_STATUS][afesc_pkg::SLEEP_POS] &&
    (regs[afesc_pkg::REG_STATUS][afesc_pkg::TONESEL_POS] ? tone_72_active : tone_40_active);

  // Register-fed analog controls
  assign ext_gain_msb = regs[afesc_pkg::REG_RXGAIN][afesc_pkg::GAIN_MSB_POS];
  assign ext_gain_lsb = regs[afesc_pkg::REG_RXGAIN][afesc_pkg::GAIN_LSB_POS];
  assign rx_pga_gain = regs[afesc_pkg::REG_RXGAIN][afesc_pkg::PGA_LO +: afesc_pkg::PGA_W];
  assign rx_atten_sel = regs[afesc_pkg::REG_RXGAIN][afesc_pkg::ATTEN_LO +: afesc_pkg::ATTEN_W];
  assign vcxo_current_out = regs[afesc_pkg::REG_VCXO][afesc_pkg::DAC_LO +: afesc_pkg::DAC_W];

  // Clock generation
  always_ff @(posedge link.pclk or negedge rstn) begin
    if (!rstn) begin
      ph <= 2'h0;
      link.word_clock <= 1'b0;
      link.master_clock_out <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      link.word_clock <= (ph == afesc_pkg::PH_LAST);
      link.master_clock_out <= link.suspend ? 1'b0 : ~link.master_clock_out;
    end
  end

  // Power and tone wake
  always_ff @(posedge link.pclk or negedge rstn) begin
    if (!rstn) begin
      low_power <= 1'b0;
      link.tone_wake_flag <= 1'b0;
    end else begin
      low_power <= link.power_down_pin;
      if (!link.suspend && !link.power_down_pin) begin
        link.tone_wake_flag <= 1'b0;
      end else if (link.suspend && !link.power_down_pin && tone_hit) begin
        link.tone_wake_flag <= 1'b1;
      end
    end
  end

  // Transmit nibbles in
  always_ff @(posedge link.pclk or negedge rstn) begin
    if (!rstn) begin
      tx_acc <= 16'h0000;
      tx_word <= 16'h0000;
      tx_word_valid <= 1'b0;
    end else begin
      tx_word_valid <= wc;
      if (wc) begin
        tx_word <= {link.tx_nibble, tx_acc[11:0]};
      end else begin
        tx_acc[{ph - 2'h1, 2'b00} +: 4] <= link.tx_nibble;
      end
    end
  end

  // Receive nibbles out
  always_ff @(posedge link.pclk or negedge rstn) begin
    if (!rstn) begin
      rx_hold <= 16'h0000;
      link.rx_nibble <= 4'h0;
    end else if (wc) begin
      rx_hold <= rx_word;
      link.rx_nibble <= afesc_pkg::nib_sel(rx_word, 2'h0);
    end else begin
      link.rx_nibble <= afesc_pkg::nib_sel(rx_hold, ph);
    end
  end

  // Control burst receiver
  always_ff @(posedge link.pclk or negedge rstn) begin
    if (!rstn) begin
      ci_st <= CI_IDLE;
      ci_cnt <= 4'h0;
      ci_sh <= 15'h0000;
      ci_rd <= 1'b0;
    end else if (wc) begin
      case (ci_st)
        CI_IDLE: begin
          if (!link.ctl_serial_in) begin
            ci_st <= CI_DATA;
            ci_cnt <= 4'h0;
            ci_rd <= link.read_write_select && debug;
          end
        end
        CI_DATA: begin
          ci_sh <= {ci_sh[13:0], link.ctl_serial_in};
          ci_cnt <= ci_cnt + 4'h1;
          if (ci_cnt == afesc_pkg::BURST_TAIL) begin
            ci_st <= CI_STOP;
          end
        end
        CI_STOP: begin
          ci_st <= CI_IDLE;
        end
        default: begin
          ci_st <= CI_IDLE;
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge link.pclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < afesc_pkg::NREG; i++) begin
        regs[i] <= afesc_pkg::reg_default(3'(i));
      end
    end else begin
      if (wr_en) begin
        if (ci_sh[2:0] == afesc_pkg::REG_STATUS && ci_sh[3 + afesc_pkg::SWRST_POS]) begin
          for (int i = 0; i < afesc_pkg::NREG; i++) begin
            regs[i] <= afesc_pkg::reg_default(3'(i));
          end
        end else begin
          regs[ci_sh[2:0]] <= ci_sh[14:3];
        end
      end
      if (rx_clip_evt) begin
        regs[afesc_pkg::REG_STATUS][afesc_pkg::RXCLIP_POS] <= 1'b1;
      end
      if (tx_clip_evt) begin
        regs[afesc_pkg::REG_STATUS][afesc_pkg::TXCLIP_POS] <= 1'b1;
      end
    end
  end

  // Readback shifter
  always_ff @(posedge link.pclk or negedge rstn) begin
    if (!rstn) begin
      out_sh <= 12'h000;
      out_cnt <= 4'h0;
      link.ctl_serial_out <= 1'b1;
      link.ctl_serial_out_oe_n <= 1'b1;
    end else begin
      link.ctl_serial_out_oe_n <= ~debug;
      if (wc) begin
        if (rd_go) begin
          out_sh <= regs[ci_sh[2:0]];
          out_cnt <= afesc_pkg::READ_BITS;
          link.ctl_serial_out <= 1'b0;
        end else if (out_cnt != 4'h0) begin
          link.ctl_serial_out <= out_sh[11];
          out_sh <= {out_sh[10:0], 1'b0};
          out_cnt <= out_cnt - 4'h1;
        end else begin
          link.ctl_serial_out <= 1'b1;
        end
      end
    end
  end
endmodule

/* rtl/afesc_host.sv */
`timescale 1ns/1ps
module afesc_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data words
  input wire logic [15:0] tx_word,
  output logic tx_word_taken,
  output logic [15:0] rx_word,
  output logic rx_word_valid,
  // Link to the front end
  afesc_if.host link
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEND = 2'b01,
    HS_WAIT = 2'b10,
    HS_RECV = 2'b11
  } afesc_hs_t;

  afesc_hs_t st;
  logic [1:0] hp;
  logic [15:0] tx_hold;
  logic [15:0] rx_acc;
  logic [15:0] cmd;
  logic pend;
  logic [15:0] fsh;
  logic [4:0] cnt;
  logic [11:0] rdata;
  logic rd_done;
  logic rd_tmo;
  logic refused;
  logic wc;
  logic acc;
  logic xfer;
  logic start;
  logic set_done;
  logic set_tmo;
  logic [31:0] rd_val;
  logic rd_ok;

  assign wc = link.word_clock;
  assign acc = psel && penable && !pready;
  assign xfer = psel && penable && pready;
  assign start = wc && (st == HS_IDLE) && pend;
  assign set_done = wc && (st == HS_RECV) && (cnt == 5'h01);
  assign set_tmo = wc && (st == HS_WAIT) && !(!link.ctl_serial_out && !link.ctl_serial_out_oe_n)
    && (cnt == 5'h01);

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr)
      afesc_pkg::OFF_CTRL: rd_val = {30'h0, link.power_down_pin, link.suspend};
      afesc_pkg::OFF_CMD: rd_val = {16'h0000, cmd};
      afesc_pkg::OFF_STATUS: rd_val = {27'h0, refused, rd_tmo, rd_done, link.tone_wake_flag,
        pend || (st != HS_IDLE)};
      afesc_pkg::OFF_RDATA: rd_val = {20'h0, rdata};
      default: rd_ok = 1'b0;
    endcase
  end

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      if (acc) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= !rd_ok;
      end
    end
  end

  // Pin controls and front-end reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.hard_reset_low <= 1'b0;
      link.suspend <= 1'b0;
      link.power_down_pin <= 1'b0;
    end else begin
      link.hard_reset_low <= 1'b1;
      if (xfer && pwrite && paddr == afesc_pkg::OFF_CTRL) begin
        link.suspend <= pwdata[0];
        link.power_down_pin <= pwdata[1];
      end
    end
  end

  // Command acceptance and sticky status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= 16'h0000;
      pend <= 1'b0;
      refused <= 1'b0;
      rd_done <= 1'b0;
      rd_tmo <= 1'b0;
    end else begin
      if (start) begin
        pend <= 1'b0;
      end
      if (xfer && pwrite && paddr == afesc_pkg::OFF_STATUS) begin
        if (pwdata[afesc_pkg::ST_RDDONE]) rd_done <= 1'b0;
        if (pwdata[afesc_pkg::ST_RDTMO]) rd_tmo <= 1'b0;
        if (pwdata[afesc_pkg::ST_REFUSED]) refused <= 1'b0;
      end
      if (xfer && pwrite && paddr == afesc_pkg::OFF_CMD) begin
        if (pend || st != HS_IDLE || link.suspend) begin
          refused <= 1'b1;
        end else begin
          cmd <= pwdata[15:0];
          pend <= 1'b1;
        end
      end
      if (set_done) rd_done <= 1'b1;
      if (set_tmo) rd_tmo <= 1'b1;
    end
  end

  // Burst engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= HS_IDLE;
      fsh <= 16'hFFFF;
      cnt <= 5'h00;
      rdata <= 12'h000;
      link.ctl_serial_in <= 1'b1;
      link.read_write_select <= 1'b0;
    end else if (wc) begin
      case (st)
        HS_IDLE: begin
          link.ctl_serial_in <= 1'b1;
          if (pend) begin
            link.ctl_serial_in <= 1'b0;
            link.read_write_select <= cmd[afesc_pkg::CMD_READ_POS];
            fsh <= {cmd[11:0], cmd[afesc_pkg::CMD_ADDR_LO +: 3], 1'b1};
            cnt <= afesc_pkg::SEND_SLOTS;
            st <= HS_SEND;
          end
        end
        HS_SEND: begin
          link.ctl_serial_in <= fsh[15];
          fsh <= {fsh[14:0], 1'b1};
          cnt <= cnt - 5'h01;
          if (cnt == 5'h01) begin
            st <= link.read_write_select ? HS_WAIT : HS_IDLE;
            cnt <= {1'b0, afesc_pkg::READ_WAIT_SLOTS};
          end
        end
        HS_WAIT: begin
          cnt <= cnt - 5'h01;
          if (!link.ctl_serial_out && !link.ctl_serial_out_oe_n) begin
            st <= HS_RECV;
            cnt <= {1'b0, afesc_pkg::READ_BITS};
          end else if (cnt == 5'h01) begin
            st <= HS_IDLE;
          end
        end
        HS_RECV: begin
          rdata <= {rdata[10:0], link.ctl_serial_out};
          cnt <= cnt - 5'h01;
          if (cnt == 5'h01) begin
            st <= HS_IDLE;
          end
        end
        default: begin
          st <= HS_IDLE;
        end
      endcase
    end
  end

  // Nibble port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp <= 2'h0;
      tx_hold <= 16'h0000;
      rx_acc <= 16'h0000;
      rx_word <= 16'h0000;
      rx_word_valid <= 1'b0;
      tx_word_taken <= 1'b0;
      link.tx_nibble <= 4'h0;
    end else begin
      hp <= wc ? 2'h1 : hp + 2'h1;
      tx_word_taken <= wc;
      rx_word_valid <= wc;
      if (wc) begin
        tx_hold <= tx_word;
        link.tx_nibble <= afesc_pkg::nib_sel(tx_word, 2'h0);
        rx_word <= {link.rx_nibble, rx_acc[11:0]};
      end else begin
        link.tx_nibble <= afesc_pkg::nib_sel(tx_hold, hp);
        rx_acc[{hp - 2'h1, 2'b00} +: 4] <= link.rx_nibble;
      end
    end
  end
endmodule

/* verification/afesc_link_props.sv */
`timescale 1ns/1ps
module afesc_link_props (
  // Clock and device reset
  input wire logic pclk,
  input wire logic hard_reset_low,
  // Host driven
  input wire logic suspend,
  input wire logic power_down_pin,
  input wire logic ctl_serial_in,
  input wire logic read_write_select,
  input wire logic [3:0] tx_nibble,
  // Device driven
  input wire logic master_clock_out,
  input wire logic word_clock,
  input wire logic ctl_serial_out,
  input wire logic ctl_serial_out_oe_n,
  input wire logic [3:0] rx_nibble,
  input wire logic tone_wake_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!hard_reset_low);

  // Word clock strobe, one cycle in four
  wclk_period_a: assert property (word_clock |=> !word_clock [*3] ##1 word_clock)
    else $error("word clock period is not four cycles");
  // Master clock toggles while not suspended
  mclk_run_a: assert property (!suspend [*3] and $past(hard_reset_low, 2)
      |-> master_clock_out != $past(master_clock_out))
    else $error("master clock not running while active");
  // Master clock held low while suspended
  mclk_stop_a: assert property (suspend [*3] |-> !master_clock_out)
    else $error("master clock running while suspended");
  // Wake flag only rises in suspend
  tone_set_a: assert property ($rose(tone_wake_flag) |-> suspend || $past(suspend))
    else $error("wake flag rose outside suspend");
  // Full operation clears the wake flag
  tone_clear_a: assert property (!suspend && !power_down_pin |-> ##[0:2] !tone_wake_flag)
    else $error("wake flag not cleared in full operation");
  // Control line moves only after a slot
  ctl_stable_a: assert property (!$past(word_clock) |-> $stable(ctl_serial_in))
    else $error("control input changed outside a slot boundary");
  // Select line moves only after a slot
  rws_stable_a: assert property (!$past(word_clock) |-> $stable(read_write_select))
    else $error("select changed outside a slot boundary");
  // Device outputs at reset values on release
  reset_vals_a: assert property ($rose(hard_reset_low) |-> !word_clock && !tone_wake_flag
      && ctl_serial_out && ctl_serial_out_oe_n && rx_nibble == 4'h0)
    else $error("device outputs not at reset values");
endmodule

/* verification/afe_serial_control_and_nibble_port_test.sv */
`timescale 1ns/1ps
module afe_serial_control_and_nibble_port_test;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] host_tx_word;
  logic [15:0] host_rx_word;
  logic host_rx_valid;
  logic [15:0] dev_rx_word;
  logic [15:0] dev_tx_word;
  logic dev_tx_valid;
  logic host_tx_taken;
  logic rx_clip;
  logic tx_clip;
  logic tone_40;
  logic tone_72;
  logic low_power;
  logic gain_msb;
  logic gain_lsb;
  logic [4:0] pga;
  logic [1:0] atten;
  logic [7:0] vcxo;
  logic [31:0] rd_q;
  logic rd_err;
  logic [11:0] d;
  logic [4:0] pga_tab [4] = '{5'h00, 5'h1F, 5'h15, 5'h0A};
  int miscompares;
  int checked;

  afesc_if afesc_if_inst (.pclk(pclk));
  afesc_host afesc_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_word(host_tx_word), .tx_word_taken(host_tx_taken),
    .rx_word(host_rx_word),
    .rx_word_valid(host_rx_valid), .link(afesc_if_inst));
  afesc_dev afesc_dev_inst (.link(afesc_if_inst), .rx_word(dev_rx_word), .tx_word(dev_tx_word),
    .tx_word_valid(dev_tx_valid), .tone_40_active(tone_40), .tone_72_active(tone_72),
    .rx_clip_evt(rx_clip), .tx_clip_evt(tx_clip), .low_power(low_power), .ext_gain_msb(gain_msb),
    .ext_gain_lsb(gain_lsb), .rx_pga_gain(pga), .rx_atten_sel(atten), .vcxo_current_out(vcxo));
  afesc_link_props afesc_link_props_inst (.pclk(pclk),
    .hard_reset_low(afesc_if_inst.hard_reset_low), .suspend(afesc_if_inst.suspend),
    .power_down_pin(afesc_if_inst.power_down_pin), .ctl_serial_in(afesc_if_inst.ctl_serial_in),
    .read_write_select(afesc_if_inst.read_write_select), .tx_nibble(afesc_if_inst.tx_nibble),
    .master_clock_out(afesc_if_inst.master_clock_out), .word_clock(afesc_if_inst.word_clock),
    .ctl_serial_out(afesc_if_inst.ctl_serial_out),
    .ctl_serial_out_oe_n(afesc_if_inst.ctl_serial_out_oe_n),
    .rx_nibble(afesc_if_inst.rx_nibble), .tone_wake_flag(afesc_if_inst.tone_wake_flag));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd_q, exp);
  endtask

  // Issue a link command and wait until the host is idle again
  task automatic cmd(input logic r, input logic [2:0] a, input logic [11:0] v);
    int n;
    apb(1'b1, afesc_pkg::OFF_CMD, {16'h0000, r, a, v});
    n = 0;
    do begin
      apb(1'b0, afesc_pkg::OFF_STATUS, 32'h0000_0000);
      n++;
    end while (rd_q[afesc_pkg::ST_BUSY] !== 1'b0 && n < 100);
    check("cmd done", rd_q[afesc_pkg::ST_BUSY], 32'h0000_0000);
    repeat (4) @(posedge pclk);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic wait_wclk();
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (afesc_if_inst.word_clock !== 1'b1 && n < 10);
  endtask

  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    host_tx_word = 16'hC3A5;
    dev_rx_word = 16'h5A3C;
    tone_40 = 1'b0;
    tone_72 = 1'b0;
    rx_clip = 1'b0;
    tx_clip = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd("status", afesc_pkg::OFF_STATUS, 32'h0000_0000);
    rd("rdata", afesc_pkg::OFF_RDATA, 32'h0000_0000);
    check("gain pins", {gain_msb, gain_lsb, pga, atten}, 32'h0000_0000);
    check("vcxo", vcxo, afesc_pkg::DEF_VCXO[11:4]);
    check("oe_n", afesc_if_inst.ctl_serial_out_oe_n, 32'h0000_0001);
    end_test("reset");
    apb(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped err", rd_err, 32'h0000_0001);
    check("unmapped data", rd_q, 32'h0000_0000);
    end_test("unmapped");
    for (int i = 0; i < 4; i++) begin
      d = {i[1:0], 1'b0, pga_tab[i], i[1:0], 2'b00};
      cmd(1'b0, afesc_pkg::REG_RXGAIN, d);
      check("gain msb", gain_msb, i[1]);
      check("gain lsb", gain_lsb, i[0]);
      check("pga", pga, pga_tab[i]);
      check("atten", atten, i[1:0]);
    end
    cmd(1'b0, afesc_pkg::REG_VCXO, 12'hA50);
    check("vcxo", vcxo, 32'h0000_00A5);
    end_test("writes");
    cmd(1'b1, afesc_pkg::REG_VCXO, 12'h5A0);
    check("read tmo", rd_q[afesc_pkg::ST_RDTMO], 32'h0000_0001);
    check("read as write", vcxo, 32'h0000_005A);
    apb(1'b1, afesc_pkg::OFF_STATUS, 32'h0000_001F);
    rd("status clr", afesc_pkg::OFF_STATUS, 32'h0000_0000);
    cmd(1'b0, afesc_pkg::REG_STATUS, 12'h080);
    check("oe_n debug", afesc_if_inst.ctl_serial_out_oe_n, 32'h0000_0000);
    cmd(1'b1, afesc_pkg::REG_RXGAIN, 12'h000);
    check("rd done", rd_q[afesc_pkg::ST_RDDONE], 32'h0000_0001);
    rd("rdata reg0", afesc_pkg::OFF_RDATA, 32'h0000_0CAC);
    check("pga kept", pga, 32'h0000_000A);
    cmd(1'b1, afesc_pkg::REG_VCXO, 12'h000);
    rd("rdata reg3", afesc_pkg::OFF_RDATA, 32'h0000_05A0);
    rx_clip <= 1'b1;
    tx_clip <= 1'b1;
    @(posedge pclk);
    rx_clip <= 1'b0;
    tx_clip <= 1'b0;
    cmd(1'b1, afesc_pkg::REG_STATUS, 12'h000);
    rd("rdata reg7", afesc_pkg::OFF_RDATA, 32'h0000_0C80);
    end_test("reads");
    apb(1'b1, afesc_pkg::OFF_CTRL, 32'h0000_0001);
    apb(1'b1, afesc_pkg::OFF_CMD, 32'h0000_0000);
    apb(1'b0, afesc_pkg::OFF_STATUS, 32'h0000_0000);
    check("refused", rd_q[afesc_pkg::ST_REFUSED], 32'h0000_0001);
    check("mclk off", afesc_if_inst.master_clock_out, 32'h0000_0000);
    apb(1'b1, afesc_pkg::OFF_CTRL, 32'h0000_0000);
    apb(1'b1, afesc_pkg::OFF_STATUS, 32'h0000_001F);
    end_test("suspend");
    for (int s = 0; s < 2; s++) begin
      cmd(1'b0, afesc_pkg::REG_STATUS, 12'h280 | (s[11:0] << afesc_pkg::TONESEL_POS));
      apb(1'b1, afesc_pkg::OFF_CTRL, 32'h0000_0001);
      tone_40 <= (s == 1);
      tone_72 <= (s == 0);
      repeat (12) @(posedge pclk);
      check("flag wrong tone", afesc_if_inst.tone_wake_flag, 32'h0000_0000);
      tone_40 <= (s == 0);
      tone_72 <= (s == 1);
      repeat (12) @(posedge pclk);
      check("flag", afesc_if_inst.tone_wake_flag, 32'h0000_0001);
      apb(1'b0, afesc_pkg::OFF_STATUS, 32'h0000_0000);
      check("status flag", rd_q[afesc_pkg::ST_TONE], 32'h0000_0001);
      tone_40 <= 1'b0;
      tone_72 <= 1'b0;
      apb(1'b1, afesc_pkg::OFF_CTRL, 32'h0000_0000);
      repeat (4) @(posedge pclk);
      check("flag cleared", afesc_if_inst.tone_wake_flag, 32'h0000_0000);
    end
    end_test("tone");
    apb(1'b1, afesc_pkg::OFF_CTRL, 32'h0000_0002);
    repeat (4) @(posedge pclk);
    check("low power", low_power, 32'h0000_0001);
    apb(1'b1, afesc_pkg::OFF_CTRL, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    check("full power", low_power, 32'h0000_0000);
    end_test("power down");
    cmd(1'b0, afesc_pkg::REG_STATUS, 12'h040);
    check("swrst gain", {gain_msb, gain_lsb, pga, atten}, 32'h0000_0000);
    check("swrst vcxo", vcxo, afesc_pkg::DEF_VCXO[11:4]);
    check("swrst oe_n", afesc_if_inst.ctl_serial_out_oe_n, 32'h0000_0001);
    end_test("software reset");
    wait_wclk();
    for (int i = 0; i < 4; i++) begin
      @(negedge pclk);
      check("tx nibble", afesc_if_inst.tx_nibble, host_tx_word[4 * i +: 4]);
      check("rx nibble", afesc_if_inst.rx_nibble, dev_rx_word[4 * i +: 4]);
    end
    repeat (8) @(negedge pclk);
    for (int n = 0; n < 8 && dev_tx_valid !== 1'b1; n++) @(negedge pclk);
    check("dev tx word", dev_tx_word, 32'h0000_C3A5);
    check("host taken", host_tx_taken, 32'h0000_0001);
    for (int n = 0; n < 8 && host_rx_valid !== 1'b1; n++) @(negedge pclk);
    check("host rx word", host_rx_word, 32'h0000_5A3C);
    end_test("nibble");
    print_verdict();
  end
endmodule
